// file: core/tmr_pkg.sv
package tmr_pkg;
    localparam logic [7:0] TIMER_COUNT_ADDR  = 8'h01;
    localparam logic [7:0] TIMER_CONFIG_ADDR = 8'h81;
    localparam logic [7:0] IRQ_CONTROL_ADDR  = 8'h0b;
    localparam logic [7:0] IRQ_CONTROL_ALT   = 8'h8b;
    localparam logic [7:0] CONFIG_RESET      = 8'hff;
    localparam int         CSS_BIT           = 5;
    localparam int         SES_BIT           = 4;
    localparam int         PSA_BIT           = 3;
    localparam int         OVF_IE_BIT        = 5;
    localparam int         OVF_FLAG_BIT      = 2;
    localparam int         INHIBIT_CYCLES    = 2;
    localparam int         PHASES            = 4;
    localparam logic [1:0] PHASE_TWO         = 2'h1;
    localparam logic [1:0] PHASE_FOUR        = 2'h3;
    localparam int         WDT_PERIOD_DEF    = 16;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

    // divider tap for a rate code: bit index of the 8-bit prescaler
    function automatic logic [2:0] rate_tap(input logic [2:0] code);
        rate_tap = code;
    endfunction
endpackage

// file: core/phase_gen.sv
`timescale 1ns/1ns
module phase_gen
    import tmr_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    output logic [1:0]            phase_out,
    output logic                  cycle_end_out
);
    import tmr_pkg::*;

    logic [1:0] phase_ff;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign phase_out     = phase_ff;
    assign cycle_end_out = (phase_ff == PHASE_FOUR);
endmodule

// file: core/prescaler.sv
`timescale 1ns/1ns
module prescaler
    import tmr_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             tick_in,
    input  wire logic             clear_in,
    input  wire logic [2:0]       rate_in,
    output logic                  div_out
);
    import tmr_pkg::*;

    logic [WIDTH-1:0] count_ff;

    initial begin
        if (WIDTH != 8) $error("prescaler width must be 8");
    end

    // single shared counter, not visible to software
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            count_ff <= '0;
        end else if (clear_in) begin
            count_ff <= '0;
        end else if (tick_in) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign div_out = count_ff[rate_tap(rate_in)];
endmodule

// file: core/timer_counter.sv
`timescale 1ns/1ns
// Operation
// - timer mode counts each instruction cycle when prescaler assigned to watchdog
// - write blocks counting for two cycles
// - counter mode counts external input edges
// - edge select picks rising or falling
// - assign bit routes prescaler counter or watchdog
// - rate divides 1:2 up to 1:256
// - wrap to zero sets overflow flag
// - interrupt only while enable bit set
// - flag stays until software clears
// - sleep halts the counter
// - prescaler output sampled on phase two, four
// - increment lags edge by fixed phases
// - one shared eight-bit prescaler
// - count write clears prescaler when assigned
// - watchdog clear clears watchdog, and prescaler when assigned
// - prescaler has no software access
module timer_counter
    import tmr_pkg::*;
#(
    parameter int WDT_PERIOD = WDT_PERIOD_DEF
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [7:0]       reg_addr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic [7:0]            reg_rdata_out,
    input  wire logic             ext_count_input_in,
    input  wire logic             sleep_in,
    input  wire logic             watchdog_clear_instr_in,
    input  wire logic             wdt_tick_in,
    output logic                  irq_out,
    output logic                  wdt_timeout_out
);
    import tmr_pkg::*;

    logic [7:0] timer_count_ff;
    logic [7:0] config_ff;
    logic       overflow_flag_ff;
    logic       overflow_irq_enable_ff;
    logic [1:0] inhibit_ff;
    logic       pin_s1_ff;
    logic       pin_s2_ff;
    logic       pin_prev_ff;
    logic       psc_s_ff;
    logic       psc_prev_ff;
    logic [7:0] rdata_ff;
    logic       irq_ff;
    logic [7:0] wdt_ff;
    logic       wdt_to_ff;
    logic [1:0] phase;
    logic       cycle_end;
    logic       count_wr;
    logic       cfg_wr;
    logic       irq_wr;
    logic       css;
    logic       ses;
    logic       prescaler_assign;
    logic       ext_edge;
    logic       src_tick;
    logic       psc_tick;
    logic       psc_clear;
    logic       psc_div;
    logic       inc_evt;
    logic       wrap;
    logic [7:0] nxt_timer_count;

    phase_gen phase_gen_inst (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .phase_out     (phase),
        .cycle_end_out (cycle_end)
    );

    assign count_wr = reg_wr_in && (reg_addr_in == TIMER_COUNT_ADDR);
    assign cfg_wr   = reg_wr_in && (reg_addr_in == TIMER_CONFIG_ADDR);
    assign irq_wr   = reg_wr_in && ((reg_addr_in == IRQ_CONTROL_ADDR) ||
                                    (reg_addr_in == IRQ_CONTROL_ALT));
    assign css = config_ff[CSS_BIT];
    assign ses = config_ff[SES_BIT];
    assign prescaler_assign = config_ff[PSA_BIT];

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            config_ff <= CONFIG_RESET;
        end else if (cfg_wr) begin
            config_ff <= reg_wdata_in;
        end
    end

    // two-flop pin synchroniser
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_s1_ff   <= 1'b0;
            pin_s2_ff   <= 1'b0;
            pin_prev_ff <= 1'b0;
        end else begin
            pin_s1_ff   <= ext_count_input_in;
            pin_s2_ff   <= pin_s1_ff;
            pin_prev_ff <= pin_s2_ff;
        end
    end

    // rising when ses clear, falling when set
    assign ext_edge = ses ? (pin_prev_ff && !pin_s2_ff)
                          : (!pin_prev_ff && pin_s2_ff);
    // source: instruction cycle or external edge
    assign src_tick = css ? ext_edge : cycle_end;
    // prescaler steps on source (counter) or watchdog tick
    assign psc_tick = sleep_in ? (prescaler_assign && wdt_tick_in)
                               : (prescaler_assign ? wdt_tick_in : src_tick);
    assign psc_clear = (!prescaler_assign && count_wr) ||
                       (prescaler_assign && watchdog_clear_instr_in);

    // one shared 8-bit counter, no register path
    prescaler #(
        .WIDTH (8)
    ) prescaler_inst (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .tick_in  (psc_tick),
        .clear_in (psc_clear),
        .rate_in  (config_ff[2:0]),
        .div_out  (psc_div)
    );

    // prescaler output sampled on phase two and four
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            psc_s_ff    <= 1'b0;
            psc_prev_ff <= 1'b0;
        end else if (phase == PHASE_TWO || phase == PHASE_FOUR) begin
            psc_s_ff    <= psc_div;
            psc_prev_ff <= psc_s_ff;
        end
    end

    // prescaled: tap carry-out, seen in the cycle after each sample
    assign inc_evt = !sleep_in && (inhibit_ff == 2'h0) &&
                     (prescaler_assign ? src_tick
                          : (((phase == PH_Q1) || (phase == PH_Q3)) &&
                             !psc_s_ff && psc_prev_ff));

    // inhibit counts down instruction cycles after a write
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            inhibit_ff <= 2'h0;
        end else if (count_wr) begin
            inhibit_ff <= 2'(INHIBIT_CYCLES);
        end else if (cycle_end && inhibit_ff != 2'h0) begin
            inhibit_ff <= inhibit_ff - 2'h1;
        end
    end

    assign wrap = inc_evt && (timer_count_ff == 8'hff);
    always_comb begin
        nxt_timer_count = timer_count_ff;
        if (count_wr) begin
            nxt_timer_count = reg_wdata_in;
        end else if (inc_evt) begin
            nxt_timer_count = timer_count_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            timer_count_ff <= 8'h00;
        end else begin
            timer_count_ff <= nxt_timer_count;
        end
    end

    // flag: hardware set wins over software clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            overflow_flag_ff       <= 1'b0;
            overflow_irq_enable_ff <= 1'b0;
        end else begin
            if (irq_wr) begin
                overflow_irq_enable_ff <= reg_wdata_in[OVF_IE_BIT];
            end
            if (wrap && !count_wr) begin
                overflow_flag_ff <= 1'b1;
            end else if (irq_wr) begin
                overflow_flag_ff <= reg_wdata_in[OVF_FLAG_BIT];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= overflow_flag_ff && overflow_irq_enable_ff;
        end
    end

    // minimal watchdog, postscaled when assigned
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wdt_ff    <= 8'h00;
            wdt_to_ff <= 1'b0;
        end else if (watchdog_clear_instr_in) begin
            wdt_ff    <= 8'h00;
            wdt_to_ff <= 1'b0;
        end else if (prescaler_assign ? (wdt_tick_in && psc_div) : wdt_tick_in) begin
            if (wdt_ff == 8'(WDT_PERIOD - 1)) begin
                wdt_ff    <= 8'h00;
                wdt_to_ff <= 1'b1;
            end else begin
                wdt_ff <= wdt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                TIMER_COUNT_ADDR:  rdata_ff <= timer_count_ff;
                TIMER_CONFIG_ADDR: rdata_ff <= config_ff;
                IRQ_CONTROL_ADDR, IRQ_CONTROL_ALT: begin
                    rdata_ff <= {2'h0, overflow_irq_enable_ff, 2'h0,
                                 overflow_flag_ff, 2'h0};
                end
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out   = rdata_ff;
    assign irq_out         = irq_ff;
    assign wdt_timeout_out = wdt_to_ff;

    initial begin
        if (WDT_PERIOD < 2 || WDT_PERIOD > 256) $error("bad WDT_PERIOD");
    end

    wrap_sets_flag_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (wrap && !count_wr) |=> overflow_flag_ff)
        else $error("wrap did not set flag");
    flag_sticky_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (overflow_flag_ff && !irq_wr) |=> overflow_flag_ff)
        else $error("flag cleared by hardware");
    irq_mask_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        irq_out |-> $past(overflow_irq_enable_ff))
        else $error("irq while masked");
    write_inhibit_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        count_wr |=> !inc_evt [*4])
        else $error("count during inhibit");
    sleep_halt_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (sleep_in && !count_wr) |=> $stable(timer_count_ff))
        else $error("count moved in sleep");
    timer_step_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (inc_evt && !count_wr) |=> timer_count_ff == $past(timer_count_ff) + 8'h01)
        else $error("bad increment");
    psc_sample_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (phase == PH_Q1 || phase == PH_Q3) |=> $stable(psc_s_ff))
        else $error("sample off phase");
    psc_route_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (prescaler_assign && !css && !sleep_in && (inhibit_ff == 2'h0) && cycle_end &&
         !count_wr) |=> timer_count_ff == $past(timer_count_ff) + 8'h01)
        else $error("prescaler route wrong");
    psc_phase_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (!prescaler_assign && inc_evt) |-> (phase == PH_Q1 || phase == PH_Q3))
        else $error("prescaled step off phase");
    cov_wrap_c: cover property (@(posedge clk_in) wrap);
    cov_ext_c: cover property (@(posedge clk_in) css && inc_evt);
    cov_irq_c: cover property (@(posedge clk_in) irq_out);
endmodule

// file: tb/count_source.sv
`timescale 1ns/1ns
module count_source (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       go_in,
    input  wire logic [7:0] edges_in,
    input  wire logic [3:0] half_in,
    output logic            pin_out,
    output logic            busy_out
);
    logic [7:0] left_ff;
    logic [3:0] gap_ff;

    assign busy_out = (left_ff != 8'h00);

    // burst of edges, each level held half_in clocks
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            left_ff <= 8'h00;
            gap_ff  <= 4'h0;
            pin_out <= 1'b0;
        end else if (go_in && !busy_out) begin
            left_ff <= edges_in;
            gap_ff  <= 4'h1;
        end else if (busy_out && gap_ff == half_in) begin
            pin_out <= ~pin_out;
            left_ff <= left_ff - 8'h01;
            gap_ff  <= 4'h1;
        end else if (busy_out) begin
            gap_ff <= gap_ff + 4'h1;
        end
    end
endmodule

// file: tb/timer_counter_with_prescaler_tb.sv
`timescale 1ns/1ns
module timer_counter_with_prescaler_tb;
    import tmr_pkg::*;
    logic       clk, rstn, wr_s, rd_s, pin, slp, clr, tick, go, irq, wto;
    logic       busy;
    logic [7:0] addr, wdat, rdat, nedge, a, b;
    logic [3:0] half;
    int         n_errors, checked;

    timer_counter #(.WDT_PERIOD(4)) timer_counter_inst (
        .clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
        .reg_wdata_in(wdat), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdat), .ext_count_input_in(pin),
        .sleep_in(slp), .watchdog_clear_instr_in(clr),
        .wdt_tick_in(tick), .irq_out(irq), .wdt_timeout_out(wto)
    );
    count_source count_source_inst (
        .clk_in(clk), .rstn_in(rstn), .go_in(go), .edges_in(nedge),
        .half_in(half), .pin_out(pin), .busy_out(busy)
    );

    task automatic wrap_up;
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        addr <= ad;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] v);
        @(posedge clk);
        addr <= ad;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        v = rdat;
    endtask
    task automatic pulse(input logic w);
        @(posedge clk);
        tick <= w;
        clr <= ~w;
        @(posedge clk);
        tick <= 1'b0;
        clr <= 1'b0;
    endtask
    task automatic burst(input logic [7:0] n);
        int k;
        @(posedge clk);
        nedge <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        cyc(1);
        for (k = 0; k < 400 && busy !== 1'b0; k++) begin
            @(posedge clk);
        end
        if (k == 400) begin
            n_errors++;
            wrap_up;
        end
        cyc(12);
    endtask

    task automatic s_regs;
        rd(TIMER_CONFIG_ADDR, a);
        chk(a, CONFIG_RESET);
        rd(IRQ_CONTROL_ADDR, a);
        chk(a, 8'h00);
        wr(8'h02, 8'h55);
        rd(8'h02, a);
        chk(a, 8'h00);
        rd(TIMER_CONFIG_ADDR, a);
        chk(a, CONFIG_RESET);
        wr(IRQ_CONTROL_ADDR, 8'hff);
        rd(IRQ_CONTROL_ALT, a);
        chk(a, 8'h24);
        chk({7'h00, irq}, 8'h01);
        wr(IRQ_CONTROL_ADDR, 8'h00);
    endtask
    task automatic s_timer;
        wr(TIMER_CONFIG_ADDR, 8'h08);
        rd(TIMER_CONFIG_ADDR, a);
        chk(a, 8'h08);
        wr(TIMER_COUNT_ADDR, 8'h40);
        rd(TIMER_COUNT_ADDR, a);
        rd(TIMER_COUNT_ADDR, a);
        chk(a, 8'h40);
        cyc(10);
        rd(TIMER_COUNT_ADDR, a);
        cyc(37);
        rd(TIMER_COUNT_ADDR, b);
        chk(b - a, 8'h0a);
    endtask
    task automatic s_ovf;
        wr(TIMER_COUNT_ADDR, 8'hfe);
        cyc(40);
        rd(IRQ_CONTROL_ADDR, a);
        chk(a, 8'h04);
        chk({7'h00, irq}, 8'h00);
        wr(IRQ_CONTROL_ADDR, 8'h24);
        cyc(2);
        chk({7'h00, irq}, 8'h01);
        cyc(200);
        rd(IRQ_CONTROL_ADDR, a);
        chk(a, 8'h24);
        wr(IRQ_CONTROL_ADDR, 8'h20);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic s_sleep;
        wr(TIMER_COUNT_ADDR, 8'hfe);
        @(posedge clk);
        slp <= 1'b1;
        cyc(100);
        rd(TIMER_COUNT_ADDR, a);
        chk(a, 8'hfe);
        chk({7'h00, irq}, 8'h00);
        @(posedge clk);
        slp <= 1'b0;
        cyc(40);
        rd(IRQ_CONTROL_ADDR, a);
        chk(a, 8'h24);
        wr(IRQ_CONTROL_ADDR, 8'h00);
    endtask
    task automatic s_presc;
        for (int n = 0; n < 8; n++) begin
            wr(TIMER_CONFIG_ADDR, 8'(n));
            wr(TIMER_COUNT_ADDR, 8'h00);
            cyc(20);
            rd(TIMER_COUNT_ADDR, a);
            cyc(8 * (2 << n) - 3);
            rd(TIMER_COUNT_ADDR, b);
            chk(b - a, 8'h02);
        end
        wr(TIMER_CONFIG_ADDR, 8'h02);
        wr(TIMER_COUNT_ADDR, 8'h00);
        cyc(20);
        wr(TIMER_COUNT_ADDR, 8'h00);
        cyc(25);
        rd(TIMER_COUNT_ADDR, a);
        chk(a, 8'h00);
        cyc(28);
        rd(TIMER_COUNT_ADDR, a);
        chk(a, 8'h01);
    endtask
    task automatic s_count;
        for (int s = 0; s < 2; s++) begin
            half <= (s == 1) ? 4'h2 : 4'h5;
            wr(TIMER_CONFIG_ADDR, (s == 1) ? 8'h38 : 8'h28);
            wr(TIMER_COUNT_ADDR, 8'h00);
            cyc(12);
            burst(8'h01);
            rd(TIMER_COUNT_ADDR, a);
            chk(a, (s == 1) ? 8'h00 : 8'h01);
            burst(8'h01);
            rd(TIMER_COUNT_ADDR, a);
            chk(a, 8'h01);
            burst(8'h06);
            rd(TIMER_COUNT_ADDR, a);
            chk(a, 8'h04);
        end
    endtask
    task automatic s_wdt;
        chk({7'h00, wto}, 8'h00);
        pulse(1'b0);
        wr(TIMER_COUNT_ADDR, 8'h00);
        wr(TIMER_CONFIG_ADDR, 8'h08);
        repeat (40) pulse(1'b1);
        cyc(2);
        chk({7'h00, wto}, 8'h01);
        pulse(1'b0);
        cyc(2);
        chk({7'h00, wto}, 8'h00);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
    initial begin
        {rstn, wr_s, rd_s, slp, clr, tick, go} = 7'h00;
        {addr, wdat, nedge} = 24'h000000;
        half = 4'h2;
        n_errors = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        s_regs;
        s_timer;
        s_ovf;
        s_sleep;
        s_presc;
        s_count;
        s_wdt;
        wrap_up;
    end
endmodule
